/* File: hdl/flash_power_pkg.sv */
/*
  Shared constants, opcodes and state encodings for the serial flash
  power-down controller and its host end.
  Assumes a single 250 MHz clock on both ends.
*/
// Function
// - Standby when deselected, idle and not asleep
// - Deep sleep ignores all but resume
// - Opcode B9h then release enters deep sleep
// - Bits after the opcode byte are discarded
// - Bad length entry aborts back to standby
// - Reset always lands in standby
// - Sleep commands ignored while program/erase busy
// - Opcode ABh then release resumes to standby
// - Bad resume framing stays in deep sleep
// - Ultra sleep entry drops buffer contents
// - Ultra sleep ignores every command
// - Opcode 79h then release enters ultra sleep
// - Chip select low pulse wakes ultra sleep
// - Dummy byte during wake pulse ignored
// - Frame started before exit elapsed ignored
// - Held low wake; early bit voids command
// - Host waits out fixed settle time, then raises ready
package flash_power_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_DEEP_SLEEP  = 8'hB9;
  localparam logic [7:0] OP_RESUME      = 8'hAB;
  localparam logic [7:0] OP_ULTRA_SLEEP = 8'h79;

  // ---------------------------------------------------------------
  // timing: figures in ns, counts in 4 ns cycles
  // ---------------------------------------------------------------
  localparam int CLOCK_MHZ                  = 250;
  localparam int DEEP_SLEEP_ENTRY_TIME_NS   = 3000;
  localparam int DEEP_SLEEP_RESUME_TIME_NS  = 8000;
  localparam int ULTRA_SLEEP_ENTRY_TIME_NS  = 3000;
  localparam int WAKE_PULSE_MIN_LOW_TIME_NS = 20;
  localparam int ULTRA_SLEEP_EXIT_TIME_NS   = 10000;
  localparam int HOST_HALF_SCLK_NS          = 64;
  localparam int HOST_GAP_NS                = 200;

  // longest times round down, least times round up
  localparam logic [15:0] DEEP_ENTRY_CYC =
    16'(DEEP_SLEEP_ENTRY_TIME_NS * CLOCK_MHZ / 1000);
  localparam logic [15:0] DEEP_RESUME_CYC =
    16'(DEEP_SLEEP_RESUME_TIME_NS * CLOCK_MHZ / 1000);
  localparam logic [15:0] ULTRA_ENTRY_CYC =
    16'(ULTRA_SLEEP_ENTRY_TIME_NS * CLOCK_MHZ / 1000);
  localparam logic [15:0] WAKE_MIN_CYC =
    16'((WAKE_PULSE_MIN_LOW_TIME_NS * CLOCK_MHZ + 999) / 1000);
  localparam logic [15:0] ULTRA_EXIT_CYC =
    16'(ULTRA_SLEEP_EXIT_TIME_NS * CLOCK_MHZ / 1000);
  localparam logic [4:0]  HALF_SCLK_CYC =
    5'((HOST_HALF_SCLK_NS * CLOCK_MHZ + 999) / 1000);
  localparam logic [15:0] GAP_CYC =
    16'((HOST_GAP_NS * CLOCK_MHZ + 999) / 1000);
  localparam logic [15:0] HOST_WAKE_LOW_CYC = WAKE_MIN_CYC + 16'h0004;

  // ---------------------------------------------------------------
  // state encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STANDBY     = 3'h0,
    ST_ENTER_DEEP  = 3'h1,
    ST_DEEP        = 3'h3,
    ST_RESUME      = 3'h2,
    ST_ENTER_ULTRA = 3'h6,
    ST_ULTRA       = 3'h7,
    ST_EXIT_ULTRA  = 3'h5
  } power_state_t;

  typedef enum logic [2:0] {
    H_IDLE    = 3'h0,
    H_SETUP   = 3'h1,
    H_SHIFT   = 3'h3,
    H_HOLD    = 3'h2,
    H_RELEASE = 3'h6,
    H_PULSE   = 3'h4
  } host_state_t;

endpackage

/* File: hdl/spi_link_if.sv */
/*
  Serial link between the host end and the flash power controller.
  Assumes the host drives all three wires; no return data is modelled.
*/
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
  logic csN;
  logic sclk;
  logic mosi;

  modport device (
    input csN,
    input sclk,
    input mosi
  );

  modport host (
    output csN,
    output sclk,
    output mosi
  );
endinterface
`default_nettype wire

/* File: hdl/sync_edge.sv */
/*
  Two-flop synchroniser with edge detection on the synchronised level.
  Assumes inputs are asynchronous to clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sync_edge #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // asynchronous inputs
  input  wire logic [WIDTH-1:0] async,
  // synchronised results
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] last;
  } sync_reg_t;

  sync_reg_t r;
  sync_reg_t next_r;

  always_comb begin
    next_r       = r;
    next_r.meta  = async;
    next_r.level = r.meta;
    next_r.last  = r.level;
  end

  // chip select idles high, so reset to all ones
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      r <= '1;
    end else begin
      r <= next_r;
    end
  end

  assign level = r.level;
  assign rise  = r.level & ~r.last;
  assign fall  = ~r.level & r.last;

endmodule
`default_nettype wire

/* File: hdl/flash_power_ctrl.sv */
/*
  Power-state controller of the flash device end: standby, deep sleep
  and ultra sleep, driven by opcodes on the serial link.
  Assumes the link is mode 0 or 3 and asynchronous to clock, and that
  progBusy comes from the program/erase engine on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_power_ctrl (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          nrst,
  // serial link
  spi_link_if.device                         link,
  // array engine status
  input  wire logic                          progBusy,
  // command and power outputs
  output logic                               cmdValid,
  output logic      [7:0]                    cmdOp,
  output flash_power_pkg::power_state_t      powerState,
  output logic                               standby,
  output logic                               buffersLost
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    flash_power_pkg::power_state_t state;
    logic [2:0]                    bitCnt;
    logic                          gotByte;
    logic [7:0]                    shiftReg;
    logic [7:0]                    opcode;
    logic                          ignoreFrame;
    logic                          clockedBit;
    logic [15:0]                   timer;
    logic [7:0]                    cmdOp;
    logic                          cmdValid;
    logic                          buffersLost;
    logic                          standby;
  } dev_reg_t;

  dev_reg_t r;
  dev_reg_t next_r;

  logic [2:0] linkLevel;
  logic [2:0] linkRise;
  logic [2:0] linkFall;
  logic       csLow;
  logic       csFall;
  logic       csRise;
  logic       sclkRise;
  logic       mosiBit;
  logic       aligned;
  logic [7:0] newByte;

  // ---------------------------------------------------------------
  // link synchronisers
  // ---------------------------------------------------------------
  sync_edge #(
    .WIDTH (3)
  ) linkSync (
    .clock (clock),
    .nrst  (nrst),
    .async ({link.mosi, link.sclk, link.csN}),
    .level (linkLevel),
    .rise  (linkRise),
    .fall  (linkFall)
  );

  assign csLow    = ~linkLevel[0];
  assign csFall   = linkFall[0];
  assign csRise   = linkRise[0];
  assign sclkRise = linkRise[1] & csLow;
  assign mosiBit  = linkLevel[2];
  assign newByte  = {r.shiftReg[6:0], mosiBit};

  // release on a whole number of bytes, at least one
  assign aligned  = r.gotByte && (r.bitCnt == 3'h0);

  function automatic logic is_power_op(input logic [7:0] op);
    is_power_op = (op == flash_power_pkg::OP_DEEP_SLEEP) ||
                  (op == flash_power_pkg::OP_ULTRA_SLEEP) ||
                  (op == flash_power_pkg::OP_RESUME);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r             = r;
    next_r.cmdValid    = 1'b0;
    next_r.buffersLost = 1'b0;

    // frame framing and opcode capture
    if (csFall) begin
      next_r.bitCnt      = 3'h0;
      next_r.gotByte     = 1'b0;
      next_r.clockedBit  = 1'b0;
      next_r.ignoreFrame = (r.state != flash_power_pkg::ST_STANDBY);
    end else if (sclkRise) begin
      next_r.shiftReg   = newByte;
      next_r.bitCnt     = r.bitCnt + 3'h1;
      next_r.clockedBit = 1'b1;
      // only the first byte counts; later bits just move the count
      if ((r.bitCnt == 3'h7) && !r.gotByte) begin
        next_r.gotByte = 1'b1;
        next_r.opcode  = newByte;
        // normal commands only pass on in standby
        if ((r.state == flash_power_pkg::ST_STANDBY) && !r.ignoreFrame &&
            !is_power_op(newByte)) begin
          next_r.cmdValid = 1'b1;
          next_r.cmdOp    = newByte;
        end
      end
    end

    case (r.state)
      flash_power_pkg::ST_STANDBY: begin
        if (csRise && aligned && !r.ignoreFrame && !progBusy) begin
          if (r.opcode == flash_power_pkg::OP_DEEP_SLEEP) begin
            next_r.state = flash_power_pkg::ST_ENTER_DEEP;
            next_r.timer = flash_power_pkg::DEEP_ENTRY_CYC;
          end else if (r.opcode == flash_power_pkg::OP_ULTRA_SLEEP) begin
            next_r.state       = flash_power_pkg::ST_ENTER_ULTRA;
            next_r.timer       = flash_power_pkg::ULTRA_ENTRY_CYC;
            next_r.buffersLost = 1'b1;
          end
        end
      end
      flash_power_pkg::ST_ENTER_DEEP: begin
        if (r.timer == 16'h0000) begin
          next_r.state = flash_power_pkg::ST_DEEP;
        end else begin
          next_r.timer = r.timer - 16'h0001;
        end
      end
      flash_power_pkg::ST_DEEP: begin
        // anything else, or a bad frame, leaves us asleep
        if (csRise && aligned &&
            (r.opcode == flash_power_pkg::OP_RESUME)) begin
          next_r.state = flash_power_pkg::ST_RESUME;
          next_r.timer = flash_power_pkg::DEEP_RESUME_CYC;
        end
      end
      flash_power_pkg::ST_RESUME: begin
        if (r.timer == 16'h0000) begin
          next_r.state = flash_power_pkg::ST_STANDBY;
        end else begin
          next_r.timer = r.timer - 16'h0001;
        end
      end
      flash_power_pkg::ST_ENTER_ULTRA: begin
        if (r.timer == 16'h0000) begin
          next_r.state = flash_power_pkg::ST_ULTRA;
          next_r.timer = 16'h0000;
        end else begin
          next_r.timer = r.timer - 16'h0001;
        end
      end
      flash_power_pkg::ST_ULTRA: begin
        // timer counts how long chip select has been low
        if (csFall) begin
          next_r.timer = 16'h0001;
        end else if (csRise) begin
          if (r.timer >= flash_power_pkg::WAKE_MIN_CYC) begin
            next_r.state = flash_power_pkg::ST_EXIT_ULTRA;
            next_r.timer = flash_power_pkg::ULTRA_EXIT_CYC;
          end else begin
            next_r.timer = 16'h0000;
          end
        end else if (csLow) begin
          if (r.timer < flash_power_pkg::ULTRA_EXIT_CYC) begin
            next_r.timer = r.timer + 16'h0001;
          end else begin
            // held low through the exit time: awake in this frame
            next_r.state       = flash_power_pkg::ST_STANDBY;
            next_r.ignoreFrame = r.clockedBit || sclkRise;
          end
        end
      end
      flash_power_pkg::ST_EXIT_ULTRA: begin
        if (r.timer == 16'h0000) begin
          next_r.state = flash_power_pkg::ST_STANDBY;
        end else begin
          next_r.timer = r.timer - 16'h0001;
        end
      end
      default: begin
        next_r.state = flash_power_pkg::ST_STANDBY;
      end
    endcase

    next_r.standby = (next_r.state == flash_power_pkg::ST_STANDBY) &&
                     !csLow && !progBusy;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      r             <= '0;
      r.state       <= flash_power_pkg::ST_STANDBY;
      r.ignoreFrame <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign cmdValid    = r.cmdValid;
  assign cmdOp       = r.cmdOp;
  assign powerState  = r.state;
  assign standby     = r.standby;
  assign buffersLost = r.buffersLost;

endmodule
`default_nettype wire

/* File: hdl/flash_power_host.sv */
/*
  Host end: sends one opcode frame or a chip select wake pulse per
  request, makes the serial clock by dividing its own clock (mode 0),
  then waits out the device's documented settle time.
  Assumes requests come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_power_host (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // serial link
  spi_link_if.host        link,
  // request side
  input  wire logic       reqValid,
  input  wire logic       reqWake,
  input  wire logic [7:0] reqOp,
  input  wire logic [3:0] reqBits,
  output logic            ready,
  output logic            done
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    flash_power_pkg::host_state_t state;
    logic                         csN;
    logic                         sclk;
    logic                         mosi;
    logic [4:0]                   div;
    logic [3:0]                   bitsLeft;
    logic [7:0]                   shiftReg;
    logic [7:0]                   op;
    logic [15:0]                  waitCnt;
    logic                         ready;
    logic                         done;
  } host_reg_t;

  host_reg_t r;
  host_reg_t next_r;
  logic      tick;

  assign tick = (r.div == flash_power_pkg::HALF_SCLK_CYC - 5'h01);

  // settle time after a frame; the device ignores early frames
  function automatic logic [15:0] settle(input logic [7:0] op);
    case (op)
      flash_power_pkg::OP_RESUME:      settle =
        flash_power_pkg::DEEP_RESUME_CYC + flash_power_pkg::GAP_CYC;
      flash_power_pkg::OP_DEEP_SLEEP:  settle =
        flash_power_pkg::DEEP_ENTRY_CYC + flash_power_pkg::GAP_CYC;
      flash_power_pkg::OP_ULTRA_SLEEP: settle =
        flash_power_pkg::ULTRA_ENTRY_CYC + flash_power_pkg::GAP_CYC;
      default:                         settle = flash_power_pkg::GAP_CYC;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    next_r.div  = tick ? 5'h00 : r.div + 5'h01;

    case (r.state)
      flash_power_pkg::H_IDLE: begin
        next_r.div = 5'h00;
        if (reqValid) begin
          next_r.ready    = 1'b0;
          next_r.csN      = 1'b0;
          next_r.op       = reqOp;
          next_r.shiftReg = reqOp;
          next_r.mosi     = reqOp[7];
          next_r.bitsLeft = reqBits;
          if (reqWake) begin
            next_r.state   = flash_power_pkg::H_PULSE;
            next_r.waitCnt = flash_power_pkg::HOST_WAKE_LOW_CYC;
          end else if (reqBits == 4'h0) begin
            next_r.state = flash_power_pkg::H_HOLD;
          end else begin
            next_r.state = flash_power_pkg::H_SETUP;
          end
        end
      end
      flash_power_pkg::H_SETUP: begin
        if (tick) begin
          next_r.state = flash_power_pkg::H_SHIFT;
        end
      end
      flash_power_pkg::H_SHIFT: begin
        if (tick) begin
          if (!r.sclk) begin
            next_r.sclk = 1'b1;
          end else begin
            // data changes on the falling edge, MSB first
            next_r.sclk     = 1'b0;
            next_r.shiftReg = {r.shiftReg[6:0], 1'b0};
            next_r.mosi     = r.shiftReg[6];
            next_r.bitsLeft = r.bitsLeft - 4'h1;
            if (r.bitsLeft == 4'h1) begin
              next_r.state = flash_power_pkg::H_HOLD;
            end
          end
        end
      end
      flash_power_pkg::H_HOLD: begin
        if (tick) begin
          next_r.csN     = 1'b1;
          next_r.mosi    = 1'b0;
          next_r.state   = flash_power_pkg::H_RELEASE;
          next_r.waitCnt = settle(r.op);
        end
      end
      flash_power_pkg::H_PULSE: begin
        if (r.waitCnt == 16'h0000) begin
          next_r.csN     = 1'b1;
          next_r.state   = flash_power_pkg::H_RELEASE;
          next_r.waitCnt = flash_power_pkg::ULTRA_EXIT_CYC +
                           flash_power_pkg::GAP_CYC;
        end else begin
          next_r.waitCnt = r.waitCnt - 16'h0001;
        end
      end
      flash_power_pkg::H_RELEASE: begin
        if (r.waitCnt == 16'h0000) begin
          next_r.state = flash_power_pkg::H_IDLE;
          next_r.ready = 1'b1;
          next_r.done  = 1'b1;
        end else begin
          next_r.waitCnt = r.waitCnt - 16'h0001;
        end
      end
      default: begin
        next_r.state = flash_power_pkg::H_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      r       <= '0;
      r.state <= flash_power_pkg::H_IDLE;
      r.csN   <= 1'b1;
      r.ready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.csN  = r.csN;
  assign link.sclk = r.sclk;
  assign link.mosi = r.mosi;
  assign ready     = r.ready;
  assign done      = r.done;

endmodule
`default_nettype wire

/* File: testbench/flash_power_asserts.sv */
/*
  Concurrent checks on the link and the device end's outputs.
  Assumes one clock domain; stay times come from package cycle counts.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_power_asserts (
  // clock and reset
  input wire logic                          clock,
  input wire logic                          nrst,
  // serial link
  input wire logic                          csN,
  input wire logic                          sclk,
  // device end
  input wire logic                          progBusy,
  input wire logic                          cmdValid,
  input wire logic [7:0]                    cmdOp,
  input wire flash_power_pkg::power_state_t powerState,
  input wire logic                          standby,
  input wire logic                          buffersLost
);
  // ---------------------------------------------------------------
  // cycles spent in the present state
  // ---------------------------------------------------------------
  flash_power_pkg::power_state_t prevState;
  logic [15:0]                   stayCnt;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prevState <= flash_power_pkg::ST_STANDBY;
      stayCnt   <= 16'h0000;
    end else begin
      prevState <= powerState;
      stayCnt   <= (powerState != prevState) ? 16'h0000 : stayCnt + 16'h0001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_reset_standby: assert property (
    $rose(nrst) |-> powerState == flash_power_pkg::ST_STANDBY)
    else $error("state after reset is not standby");
  a_standby_level: assert property (
    standby |-> powerState == flash_power_pkg::ST_STANDBY
                && !$past(progBusy))
    else $error("standby raised outside idle standby");
  a_deep_ignores: assert property (
    $past(powerState) == flash_power_pkg::ST_DEEP |-> powerState inside
      {flash_power_pkg::ST_DEEP, flash_power_pkg::ST_RESUME})
    else $error("deep sleep left by something other than resume");
  a_deep_entry: assert property (
    powerState == flash_power_pkg::ST_ENTER_DEEP && prevState == powerState
    |-> stayCnt < flash_power_pkg::DEEP_ENTRY_CYC ##1 powerState inside
      {flash_power_pkg::ST_ENTER_DEEP, flash_power_pkg::ST_DEEP})
    else $error("deep sleep entry too long or wrong target");
  a_resume_time: assert property (
    powerState == flash_power_pkg::ST_RESUME && prevState == powerState
    |-> stayCnt < flash_power_pkg::DEEP_RESUME_CYC ##1 powerState inside
      {flash_power_pkg::ST_RESUME, flash_power_pkg::ST_STANDBY})
    else $error("resume too long or wrong target");
  a_lost_on_ultra: assert property (
    buffersLost |-> ##[0:2] powerState == flash_power_pkg::ST_ENTER_ULTRA)
    else $error("buffer loss without ultra sleep entry");
  a_ultra_ignores: assert property (
    $past(powerState) == flash_power_pkg::ST_ULTRA |-> powerState inside
      {flash_power_pkg::ST_ULTRA, flash_power_pkg::ST_EXIT_ULTRA} ||
      (powerState == flash_power_pkg::ST_STANDBY && !csN))
    else $error("ultra sleep left by a command");
  a_ultra_entry: assert property (
    powerState == flash_power_pkg::ST_ENTER_ULTRA && prevState == powerState
    |-> stayCnt < flash_power_pkg::ULTRA_ENTRY_CYC ##1 powerState inside
      {flash_power_pkg::ST_ENTER_ULTRA, flash_power_pkg::ST_ULTRA})
    else $error("ultra sleep entry too long or wrong target");
  a_exit_time: assert property (
    powerState == flash_power_pkg::ST_EXIT_ULTRA && prevState == powerState
    |-> stayCnt < flash_power_pkg::ULTRA_EXIT_CYC ##1 powerState inside
      {flash_power_pkg::ST_EXIT_ULTRA, flash_power_pkg::ST_STANDBY})
    else $error("ultra sleep exit too long or wrong target");
  a_cmd_standby: assert property (
    cmdValid |-> $past(powerState) == flash_power_pkg::ST_STANDBY
                 && !(cmdOp inside {8'hB9, 8'hAB, 8'h79}))
    else $error("command passed outside standby");
  a_link_idle: assert property (
    csN |-> !sclk)
    else $error("serial clock high while deselected");
endmodule
`default_nettype wire

/* File: testbench/serial_flash_power_down_control_tb_top.sv */
/*
  Bench: host end drives a device end over one link; a second device
  end is driven raw by the bench for framing the host cannot make.
  Assumes a 250 MHz clock and the package's cycle counts.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_flash_power_down_control_tb_top;
  typedef flash_power_pkg::power_state_t state_t;
  typedef struct packed {
    logic [7:0] op;
    logic [3:0] bits;
    logic       busy;
    state_t     exp;
  } step_t;
  localparam state_t SB = flash_power_pkg::ST_STANDBY;
  localparam state_t DP = flash_power_pkg::ST_DEEP;
  localparam state_t UL = flash_power_pkg::ST_ULTRA;

  logic       clock, nrst, progBusy, reqValid, reqWake, ready, done;
  logic       cmdValid, cmdValidRaw, standby, buffersLost;
  logic [7:0] reqOp, cmdOp;
  logic [3:0] reqBits;
  state_t     powerState, powerStateRaw;
  int         failCount, comparisons, cycles, cmdCount, lostCount, rawCmds;
  step_t      steps [12] = '{
    '{8'hB9, 4'h7, 1'b0, SB},
    '{8'hB9, 4'hC, 1'b0, SB},
    '{8'hB9, 4'h0, 1'b0, SB},
    '{8'hB9, 4'h8, 1'b1, SB},
    '{8'hB9, 4'hF, 1'b0, SB},
    '{8'hB9, 4'h8, 1'b0, DP},
    '{8'h05, 4'h8, 1'b0, DP},
    '{8'h79, 4'h8, 1'b0, DP},
    '{8'hAB, 4'h7, 1'b0, DP},
    '{8'hAB, 4'hC, 1'b0, DP},
    '{8'hAB, 4'hF, 1'b0, DP},
    '{8'hAB, 4'h8, 1'b0, SB}};

  spi_link_if linkA ();
  spi_link_if linkB ();

  flash_power_host flash_power_host_inst (.clock(clock), .nrst(nrst),
    .link(linkA.host), .reqValid(reqValid), .reqWake(reqWake),
    .reqOp(reqOp), .reqBits(reqBits), .ready(ready), .done(done));
  flash_power_ctrl flash_power_ctrl_inst (.clock(clock), .nrst(nrst),
    .link(linkA.device), .progBusy(progBusy), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .powerState(powerState), .standby(standby),
    .buffersLost(buffersLost));
  flash_power_ctrl flash_power_ctrl_raw_inst (.clock(clock), .nrst(nrst),
    .link(linkB.device), .progBusy(1'b0), .cmdValid(cmdValidRaw),
    .cmdOp(), .powerState(powerStateRaw), .standby(), .buffersLost());
  flash_power_asserts flash_power_asserts_inst (.clock(clock), .nrst(nrst),
    .csN(linkA.csN), .sclk(linkA.sclk), .progBusy(progBusy),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .powerState(powerState),
    .standby(standby), .buffersLost(buffersLost));

  // ---------------------------------------------------------------
  // clock, event counts and hang limit
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cmdValid === 1'b1) cmdCount++;
    if (cmdValidRaw === 1'b1) rawCmds++;
    if (buffersLost === 1'b1) lostCount++;
    if (cycles == 90000) begin
      failCount++;
      $display("mismatch at %0t: timeout", $time);
      printVerdict();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one host request, then wait for its done pulse
  task automatic send(input logic [7:0] op, input logic [3:0] bits,
                      input logic wake);
    int n;
    @(negedge clock);
    reqValid = 1'b1;
    reqOp    = op;
    reqBits  = bits;
    reqWake  = wake;
    @(negedge clock);
    reqValid = 1'b0;
    for (n = 0; n < 8000 && done !== 1'b1; n++) @(negedge clock);
    check({7'h00, done}, 8'h01);
  endtask

  // raw frame on the second link; bench link clock period 125 ns
  task automatic raw(input logic [7:0] op, input int bits, input int hold);
    linkB.csN = 1'b0;
    for (int i = 0; i < bits; i++) begin
      linkB.mosi = (i < 8) ? op[7 - i] : 1'b1;
      #62.5 linkB.sclk = 1'b1;
      #62.5 linkB.sclk = 1'b0;
    end
    repeat (hold) @(negedge clock);
    linkB.csN  = 1'b1;
    linkB.mosi = ~linkB.mosi;
    repeat (20) @(negedge clock);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    progBusy = 1'b0;
    reqValid = 1'b0;
    reqWake = 1'b0;
    reqOp = 8'h00;
    reqBits = 4'h0;
    linkB.csN = 1'b1;
    linkB.sclk = 1'b0;
    linkB.mosi = 1'b0;
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    check({5'h00, powerState}, {5'h00, SB});
    check({7'h00, standby}, 8'h01);
    send(8'h05, 4'h8, 1'b0);
    check(cmdOp, 8'h05);
    foreach (steps[i]) begin
      progBusy = steps[i].busy;
      send(steps[i].op, steps[i].bits, 1'b0);
      progBusy = 1'b0;
      check({5'h00, powerState}, {5'h00, steps[i].exp});
    end
    send(8'h79, 4'h9, 1'b0);
    check({5'h00, powerState}, {5'h00, SB});
    send(8'h79, 4'h8, 1'b0);
    check({5'h00, powerState}, {5'h00, UL});
    send(8'hAB, 4'h8, 1'b0);
    repeat (int'(flash_power_pkg::ULTRA_EXIT_CYC)) @(negedge clock);
    check({5'h00, powerState}, {5'h00, SB});
    check(8'(cmdCount), 8'h01);
    send(8'h79, 4'h8, 1'b0);
    check({5'h00, powerState}, {5'h00, UL});
    send(8'h00, 4'h0, 1'b1);
    check({5'h00, powerState}, {5'h00, SB});
    check(8'(lostCount), 8'h02);
    raw(8'h79, 16, 4);
    repeat (int'(flash_power_pkg::ULTRA_ENTRY_CYC) + 20) @(negedge clock);
    check({5'h00, powerStateRaw}, {5'h00, UL});
    raw(8'h00, 0, 2);
    check({5'h00, powerStateRaw}, {5'h00, UL});
    raw(8'h00, 0, 10);
    raw(8'hB9, 8, 4);
    repeat (int'(flash_power_pkg::ULTRA_EXIT_CYC) + 40) @(negedge clock);
    check({5'h00, powerStateRaw}, {5'h00, SB});
    raw(8'h79, 8, 4);
    repeat (int'(flash_power_pkg::ULTRA_ENTRY_CYC) + 20) @(negedge clock);
    raw(8'h05, 8, int'(flash_power_pkg::ULTRA_EXIT_CYC) + 20);
    check({5'h00, powerStateRaw}, {5'h00, SB});
    check(8'(rawCmds), 8'h00);
    printVerdict();
  end
endmodule
`default_nettype wire
